/* File: inc/emb_consts.vh */
`ifndef EMB_CONSTS_VH
`define EMB_CONSTS_VH

// bus cycle phase timing, in oscillator clocks
`define EMB_CYCLE_CLKS    6
`define EMB_ALE_HIGH_END  2
`define EMB_ADDR_END      3
`define EMB_FETCH_LOW_BEG 3
// top of internal code space
`define EMB_INT_CODE_TOP  16'h1fff
// bus request kinds
`define EMB_OP_FETCH      2'h0
`define EMB_OP_RD         2'h1
`define EMB_OP_WR         2'h2
// data cycle length, in six-clock cycles
`define EMB_DATA_CYCLES   2
`endif

/* File: rtl/emb_phase.v */
`timescale 1ns/1ps
`include "emb_consts.vh"
// ------------------------------------------------
// six-state machine-cycle phase counter
// ------------------------------------------------
module emb_phase #(
  parameter CYCLE = `EMB_CYCLE_CLKS
) (
  input  wire       clk,     // oscillator clock
  input  wire       rst_n,   // async reset, low
  output reg  [2:0] phase,   // phase within cycle
  output wire       last     // last phase of cycle
);
  assign last = (phase == CYCLE - 1);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 3'h0;
    end else if (last) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
endmodule // emb_phase

/* File: rtl/emb_strap.v */
`timescale 1ns/1ps
// ------------------------------------------------
// download strap capture at reset release
// ------------------------------------------------
module emb_strap (
  input  wire clk,       // oscillator clock
  input  wire rst_n,     // async reset, low
  input  wire pin_in,    // sensed strobe line
  output reg  dl_mode    // serial download selected
);
  reg armed_reg;
  // the first clock after release samples the line, while our driver is still off
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b1;
      dl_mode   <= 1'b0;
    end else if (armed_reg) begin
      armed_reg <= 1'b0;
      dl_mode   <= ~pin_in;
    end
  end
endmodule // emb_strap

/* File: rtl/emb_bus_port.v */
`timescale 1ns/1ps
`include "emb_consts.vh"
module emb_bus_port (
  input  wire        MCLK,        // 200 MHz oscillator clock
  input  wire        RST_N,       // async reset, low
  input  wire        EXT_FETCH_SELECT, // high: internal code allowed
  input  wire [15:0] FETCH_ADDR,  // core program counter
  input  wire        REQ_VALID,   // core data access request
  input  wire [1:0]  REQ_OP,      // read or write
  input  wire [23:0] REQ_ADDR,    // data address
  input  wire [7:0]  REQ_WDATA,   // write byte
  output wire        REQ_READY,   // request taken
  output reg  [7:0]  RDATA,       // read or fetched byte
  output reg         RDATA_VALID, // rdata pulse
  output reg         FETCH_EXT,   // current fetch is external
  output wire        DOWNLOAD_MODE, // serial download selected
  input  wire [7:0]  LOW_PORT_GPIO_LATCH,  // low port latch as gpio
  input  wire [7:0]  HIGH_PORT_GPIO_LATCH, // high port latch as gpio
  input  wire        FETCH_STROBE_IN,      // fetch strobe pin level
  output reg         PROGRAM_FETCH_STROBE, // fetch strobe, low active
  output reg         FETCH_STROBE_OE_N,    // fetch strobe drive enable, low
  output reg         ALE,         // address latch strobe
  output reg         WR_N,        // write strobe
  output reg         RD_N,        // read strobe
  input  wire [7:0]  LOW_ADDRESS_DATA_PORT_IN,  // low port level
  output reg  [7:0]  LOW_ADDRESS_DATA_PORT_OUT, // low port output
  output reg  [7:0]  LOW_ADDRESS_DATA_PORT_OE_N, // low port enable, low
  output reg  [7:0]  HIGH_ADDRESS_PORT_OUT,     // high port output
  output reg  [7:0]  HIGH_ADDRESS_PORT_OE_N,    // high port strong enable, low
  output reg  [7:0]  HIGH_ADDRESS_PORT_PULLUP   // high port weak pull-up on
);
  // ------------------------------------------------
  // state
  // ------------------------------------------------
  localparam ST_CODE = 2'h0;
  localparam ST_DATA = 2'h1;

  wire [2:0] phase;
  wire       last;
  reg  [1:0] st_reg;
  reg  [1:0] op_reg;
  reg  [23:0] addr_reg;
  reg  [7:0]  wdata_reg;
  reg  [1:0]  dcnt_reg;
  reg         ext_reg;
  reg         boot_reg;

  emb_phase #(
    .CYCLE (`EMB_CYCLE_CLKS)
  ) u_phase (
    .clk   (MCLK),
    .rst_n (RST_N),
    .phase (phase),
    .last  (last)
  );

  emb_strap u_strap (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .pin_in  (FETCH_STROBE_IN),
    .dl_mode (DOWNLOAD_MODE)
  );

  // ------------------------------------------------
  // fetch target decode
  // ------------------------------------------------
  function is_ext_fetch;
    input        sel;
    input [15:0] a;
    begin
      is_ext_fetch = ~sel | (a > `EMB_INT_CODE_TOP);
    end
  endfunction

  // data requests are taken only at a cycle boundary in code state
  assign REQ_READY = (st_reg == ST_CODE) && last && !boot_reg;

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg    <= ST_CODE;
      op_reg    <= `EMB_OP_FETCH;
      addr_reg  <= 24'h000000;
      wdata_reg <= 8'h00;
      dcnt_reg  <= 2'h0;
      ext_reg   <= 1'b0;
      boot_reg  <= 1'b1;
      FETCH_EXT <= 1'b0;
    end else begin
      if (last) begin
        boot_reg <= 1'b0;
      end
      case (st_reg)
        ST_CODE: begin
          if (last) begin
            if (REQ_VALID && !boot_reg) begin
              st_reg    <= ST_DATA;
              op_reg    <= REQ_OP;
              addr_reg  <= REQ_ADDR;
              wdata_reg <= REQ_WDATA;
              dcnt_reg  <= 2'h0;
              ext_reg   <= 1'b0;
            end else begin
              op_reg   <= `EMB_OP_FETCH;
              addr_reg <= {8'h00, FETCH_ADDR};
              ext_reg  <= is_ext_fetch(EXT_FETCH_SELECT, FETCH_ADDR);
            end
            FETCH_EXT <= is_ext_fetch(EXT_FETCH_SELECT, FETCH_ADDR);
          end
        end
        ST_DATA: begin
          if (last) begin
            if (dcnt_reg == `EMB_DATA_CYCLES - 1) begin
              st_reg  <= ST_CODE;
              op_reg  <= `EMB_OP_FETCH;
              ext_reg <= 1'b0;
            end else begin
              dcnt_reg <= dcnt_reg + 2'h1;
            end
          end
        end
        default: begin
          st_reg <= ST_CODE;
        end
      endcase
    end
  end

  // ------------------------------------------------
  // pin sequencing
  // ------------------------------------------------
  wire in_data   = (st_reg == ST_DATA);
  wire data_fst  = in_data && (dcnt_reg == 2'h0);
  wire data_end  = in_data && (dcnt_reg == `EMB_DATA_CYCLES - 1);
  wire fetch_act = (st_reg == ST_CODE) && ext_reg && !boot_reg;
  wire addr_ph   = (phase < `EMB_ADDR_END);

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PROGRAM_FETCH_STROBE       <= 1'b1;
      FETCH_STROBE_OE_N          <= 1'b1;
      ALE                        <= 1'b0;
      WR_N                       <= 1'b1;
      RD_N                       <= 1'b1;
      LOW_ADDRESS_DATA_PORT_OUT  <= 8'hff;
      LOW_ADDRESS_DATA_PORT_OE_N <= 8'hff;
      HIGH_ADDRESS_PORT_OUT      <= 8'hff;
      HIGH_ADDRESS_PORT_OE_N     <= 8'hff;
      HIGH_ADDRESS_PORT_PULLUP   <= 8'hff;
      RDATA                      <= 8'h00;
      RDATA_VALID                <= 1'b0;
    end else begin
      FETCH_STROBE_OE_N <= boot_reg;
      RDATA_VALID <= 1'b0;
      // fetch strobe low in second half of an external code cycle only
      PROGRAM_FETCH_STROBE <= ~(fetch_act && phase >= `EMB_FETCH_LOW_BEG);
      // latch strobe in every code cycle but the first after reset, and in the address cycle of a data access
      ALE <= ((st_reg == ST_CODE && !boot_reg) || data_fst)
             && (phase < `EMB_ALE_HIGH_END);
      RD_N <= ~(data_end && op_reg == `EMB_OP_RD);
      WR_N <= ~(data_end && op_reg == `EMB_OP_WR);
      if (fetch_act || in_data) begin
        if (fetch_act ? addr_ph : data_fst) begin
          // address stands through the latch strobe fall
          LOW_ADDRESS_DATA_PORT_OUT  <= addr_reg[7:0];
          LOW_ADDRESS_DATA_PORT_OE_N <= 8'h00;
        end else if (in_data && op_reg == `EMB_OP_WR) begin
          LOW_ADDRESS_DATA_PORT_OUT  <= wdata_reg;
          LOW_ADDRESS_DATA_PORT_OE_N <= 8'h00;
        end else begin
          // released so memory can drive
          LOW_ADDRESS_DATA_PORT_OUT  <= 8'hff;
          LOW_ADDRESS_DATA_PORT_OE_N <= 8'hff;
        end
        // page byte rides the high port while the latch strobe is up in a data access, middle byte after; fetches carry the middle byte
        if (data_fst && phase < `EMB_ALE_HIGH_END) begin
          HIGH_ADDRESS_PORT_OUT <= addr_reg[23:16];
        end else begin
          HIGH_ADDRESS_PORT_OUT <= addr_reg[15:8];
        end
        HIGH_ADDRESS_PORT_OE_N   <= 8'h00;
        HIGH_ADDRESS_PORT_PULLUP <= 8'h00;
      end else begin
        // general i/o: zeros pull low, ones float or weakly pull up
        LOW_ADDRESS_DATA_PORT_OUT  <= 8'h00;
        LOW_ADDRESS_DATA_PORT_OE_N <= LOW_PORT_GPIO_LATCH;
        HIGH_ADDRESS_PORT_OUT      <= 8'h00;
        HIGH_ADDRESS_PORT_OE_N     <= HIGH_PORT_GPIO_LATCH;
        HIGH_ADDRESS_PORT_PULLUP   <= HIGH_PORT_GPIO_LATCH;
      end
      if ((fetch_act && last) || (data_end && last && op_reg == `EMB_OP_RD)) begin
        RDATA       <= LOW_ADDRESS_DATA_PORT_IN;
        RDATA_VALID <= 1'b1;
      end
    end
  end
endmodule // emb_bus_port

/* File: tb/emb_bus_port_sva.sv */
`timescale 1ns/1ps
// ----------------
// bus port checker
// ----------------
module emb_bus_port_sva (
  input wire       MCLK,                      // clock
  input wire       RST_N,                     // reset
  input wire       FETCH_EXT,                 // ext fetch
  input wire       PROGRAM_FETCH_STROBE,      // fetch
  input wire       ALE,                       // latch
  input wire       RD_N,                      // read
  input wire       WR_N,                      // write
  input wire [7:0] LOW_ADDRESS_DATA_PORT_OE_N // enable
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire data_n = RD_N & WR_N;
  wire fstb   = PROGRAM_FETCH_STROBE;
  chk_fstb_ext: assert property ($fell(fstb) |-> FETCH_EXT)
    else $error("fetch strobe on internal code");
  chk_fstb_width: assert property ($fell(fstb) |-> !fstb[*3] ##1 fstb)
    else $error("fetch strobe width");
  chk_ale_width: assert property ($rose(ALE) |-> ALE[*2] ##1 !ALE)
    else $error("latch strobe width");
  chk_ale_period: assert property ($rose(ALE) |-> ##[5:7] (ALE || !data_n))
    else $error("latch strobe period");
  chk_data_quiet: assert property (!data_n |-> fstb && !ALE)
    else $error("strobe in data cycle");
  chk_rd_width: assert property ($fell(RD_N) |-> !RD_N[*6] ##1 RD_N)
    else $error("read strobe width");
  chk_wr_width: assert property ($fell(WR_N) |-> !WR_N[*6] ##1 WR_N)
    else $error("write strobe width");
  chk_wr_drive: assert property (!WR_N |-> LOW_ADDRESS_DATA_PORT_OE_N == 8'h00)
    else $error("write data not driven");
  chk_rd_release: assert property (!RD_N |-> &LOW_ADDRESS_DATA_PORT_OE_N)
    else $error("port driven in read");
  chk_addr_first: assert property ($fell(ALE) && FETCH_EXT
    |-> $past(LOW_ADDRESS_DATA_PORT_OE_N) == 8'h00)
    else $error("address missing at latch");
  cov_rd: cover property ($fell(RD_N));
  cov_wr: cover property ($fell(WR_N));
  cov_fetch: cover property ($fell(fstb));
endmodule // emb_bus_port_sva
bind emb_bus_port emb_bus_port_sva u_sva (.MCLK(MCLK), .RST_N(RST_N),
  .FETCH_EXT(FETCH_EXT), .PROGRAM_FETCH_STROBE(PROGRAM_FETCH_STROBE), .ALE(ALE),
  .RD_N(RD_N), .WR_N(WR_N), .LOW_ADDRESS_DATA_PORT_OE_N(LOW_ADDRESS_DATA_PORT_OE_N));

/* File: tb/emb_mem_model.sv */
`timescale 1ns/1ps
// -----------------------
// external memory + latch
// -----------------------
module emb_mem_model (
  input  wire       clk,     // clock
  input  wire       ale,     // latch
  input  wire       fetch_n, // fetch
  input  wire       rd_n,    // read
  input  wire       wr_n,    // write
  input  wire [7:0] lo_out,  // low out
  input  wire [7:0] lo_oe_n, // low enable
  input  wire [7:0] hi_out,  // high out
  output wire [7:0] lo_lvl   // low level
);
  reg [7:0] mem [0:255];
  reg [7:0] a_lo = 8'h00;
  reg [7:0] a_pg = 8'h00;
  reg [7:0] last = 8'h00;
  integer   j;
  initial for (j = 0; j < 256; j++) mem[j] = j[7:0] ^ 8'h5a;
  // memory only drives while the read or fetch strobe is low; a floating bit moves every cycle
  wire       drv = ~rd_n | ~fetch_n;
  // page byte is latched with the low byte; the middle byte is taken live
  wire [7:0] ix  = a_lo ^ hi_out ^ a_pg;
  wire [7:0] rb  = drv ? mem[ix] : ~last;
  assign lo_lvl = (~lo_oe_n & lo_out) | (lo_oe_n & rb);
  always @(posedge clk) begin
    last <= lo_lvl;
    if (ale) begin
      a_lo <= lo_lvl;
      a_pg <= hi_out;
    end
    if (!wr_n) mem[ix] <= lo_lvl;
  end
endmodule // emb_mem_model

/* File: tb/external_memory_bus_port_bench.sv */
`timescale 1ns/1ps
`include "emb_consts.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
// -----------------
// bench top
// -----------------
module external_memory_bus_port_bench;
  reg         mclk = 0, rst_n = 0, sel = 1, strap = 1, req_valid = 0;
  reg  [15:0] fetch_addr = 16'h0100;
  reg  [1:0]  req_op = 2'h0;
  reg  [23:0] req_addr = 24'h0, a;
  reg  [7:0]  req_wdata = 8'h00, p0_latch = 8'hff, p2_latch = 8'hff, d, e;
  wire        req_ready, rdata_valid, fetch_ext, dl_mode, fstb, fstb_oe_n, ale, wr_n, rd_n;
  wire [7:0]  rdata, lo_in, lo_out, lo_oe_n, hi_out, hi_oe_n, hi_pu;
  wire        fstb_pin = fstb_oe_n ? strap : fstb;
  reg  [7:0]  shadow [0:255];
  reg  [7:0]  q [$];
  integer     n_errors = 0, n_checks = 0, i, k;
  always #2.5 mclk = ~mclk;
  emb_bus_port u_dut (.MCLK(mclk), .RST_N(rst_n), .EXT_FETCH_SELECT(sel),
    .FETCH_ADDR(fetch_addr), .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RDATA(rdata), .RDATA_VALID(rdata_valid),
    .FETCH_EXT(fetch_ext), .DOWNLOAD_MODE(dl_mode), .LOW_PORT_GPIO_LATCH(p0_latch),
    .HIGH_PORT_GPIO_LATCH(p2_latch), .FETCH_STROBE_IN(fstb_pin), .PROGRAM_FETCH_STROBE(fstb),
    .FETCH_STROBE_OE_N(fstb_oe_n), .ALE(ale), .WR_N(wr_n), .RD_N(rd_n),
    .LOW_ADDRESS_DATA_PORT_IN(lo_in), .LOW_ADDRESS_DATA_PORT_OUT(lo_out),
    .LOW_ADDRESS_DATA_PORT_OE_N(lo_oe_n), .HIGH_ADDRESS_PORT_OUT(hi_out),
    .HIGH_ADDRESS_PORT_OE_N(hi_oe_n), .HIGH_ADDRESS_PORT_PULLUP(hi_pu));
  emb_mem_model u_mem (.clk(mclk), .ale(ale), .fetch_n(fstb), .rd_n(rd_n), .wr_n(wr_n),
    .lo_out(lo_out), .lo_oe_n(lo_oe_n), .hi_out(hi_out), .lo_lvl(lo_in));
  task end_sim;
    begin
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task do_reset(input reg s, input integer n);
    begin
      rst_n = 0;
      strap = s;
      repeat (n) @(negedge mclk);
      rst_n = 1;
      repeat (8) @(negedge mclk);
    end
  endtask
  // one access at a time, then a gap wider than the data cycle pair
  task access(input [1:0] op, input [23:0] ad, input [7:0] wd);
    begin
      req_op = op;
      req_addr = ad;
      req_wdata = wd;
      req_valid = 1;
      for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge mclk);
      @(negedge mclk);
      req_valid = 0;
      if (k == 50) n_errors++;
      repeat (20) @(negedge mclk);
    end
  endtask
  always @(posedge mclk) if (rdata_valid === 1'b1 && q.size() > 0) begin
    e = q.pop_front();
    `CHK("rdata", e, rdata)
  end
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hb4f1));
    for (i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5a;
    p0_latch = $urandom;
    p2_latch = $urandom;
    fetch_addr = $urandom & 16'h1fff;
    do_reset(1'b0, 6);
    `CHK("dl_mode", 1'b1, dl_mode)
    do_reset(1'b1, 24);
    `CHK("dl_mode", 1'b0, dl_mode)
    `CHK("lo_oe_n", p0_latch, lo_oe_n)
    `CHK("hi_oe_n", p2_latch, hi_oe_n)
    `CHK("hi_pullup", p2_latch, hi_pu)
    `CHK("fstb_idle", 1'b1, fstb)
    `CHK("fetch_ext", 1'b0, fetch_ext)
    for (i = 0; i < 9; i++) begin
      a = $urandom;
      d = $urandom;
      if (i < 8) shadow[a[7:0] ^ a[15:8] ^ a[23:16]] = d;
      if (i < 8) access(`EMB_OP_WR, a, d);
      q.push_back(shadow[a[7:0] ^ a[15:8] ^ a[23:16]]);
      access(`EMB_OP_RD, a, 8'h00);
    end
    fetch_addr = 16'h1fff;
    repeat (12) @(negedge mclk);
    `CHK("fetch_ext", 1'b0, fetch_ext)
    fetch_addr = 16'h2000;
    repeat (12) @(negedge mclk);
    `CHK("fetch_ext", 1'b1, fetch_ext)
    sel = 0;
    fetch_addr = $urandom & 16'h1fff;
    repeat (12) @(negedge mclk);
    `CHK("fetch_ext", 1'b1, fetch_ext)
    for (i = 0; i < 4; i++) q.push_back(shadow[fetch_addr[7:0]]);
    for (k = 0; k < 100 && q.size() > 0; k++) @(negedge mclk);
    `CHK("fetches", 0, q.size())
    end_sim;
  end
endmodule // external_memory_bus_port_bench
